// *** rtl/asv_pkg.sv ***
package asv_pkg;
	// Register byte offsets on the AXI4-Lite slave.
	localparam logic [7:0] ASV_CTRL_ADDR = 8'h00;
	localparam logic [7:0] ASV_STAT_ADDR = 8'h04;
	localparam logic [7:0] ASV_VEC_ADDR = 8'h08;
	// Control register fields.
	localparam int ASV_START_BIT = 0;
	localparam int ASV_EXT_EN_BIT = 4;
	localparam int ASV_CLK_EN_BIT = 5;
	localparam int ASV_DONE_IE_BIT = 6;
	localparam int ASV_CHAN_LSB = 8;
	localparam int ASV_ERR_IE_BIT = 14;
	localparam int ASV_ERR_BIT = 15;
	// Status register fields.
	localparam int ASV_DONE_BIT = 7;
	localparam int ASV_SETTLE_BIT = 1;
	localparam int ASV_BUSY_BIT = 2;
	localparam int ASV_SE_BIT = 3;
	localparam int ASV_ERRIRQ_BIT = 4;
	// Vector defaults and spacing (octal 400, four words = octal 10 bytes).
	localparam logic [8:0] ASV_VEC_DEFAULT = 9'o400;
	localparam logic [8:0] ASV_ERR_VEC_STEP = 9'o010;
	// Timing.
	localparam int ASV_CLK_MHZ = 200;
	localparam int ASV_SETTLE_US = 9;
	localparam int ASV_SETTLE_CYC = ASV_SETTLE_US * ASV_CLK_MHZ;
	localparam int ASV_CONV_STEPS = 13;
	localparam int ASV_STEP_CYC = 4;
	localparam logic [1:0] ASV_RESP_OKAY = 2'b00;
	localparam logic [1:0] ASV_RESP_SLVERR = 2'b10;
endpackage : asv_pkg

// *** rtl/asv_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// Three-stage synchroniser; the output changes once stages two and three agree.
module asv_sync (
	input wire logic aclk, // Clock.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic rst_val, // Level assumed during reset.
	input wire logic din, // Asynchronous input.
	output logic dout // Filtered synchronous level.
);
	logic [2:0] stage;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage <= {3{rst_val}};
		end else begin
			stage <= {stage[1:0], din};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dout <= rst_val;
		end else if (stage[1] == stage[2]) begin
			dout <= stage[2];
		end
	end
endmodule : asv_sync
`default_nettype wire

// *** rtl/asv_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Done vector taken from switch bank, 000-777.
// - Shipped switch setting yields vector 400.
// - Error vector equals done vector plus four words.
// - No jumper quasi-differential, jumper fitted single-ended.
// - Grounded mode pin forces single-ended mode.
// - Settling interval 9 us; hardware starts then flag error, software starts wait.
// - Channel change and conversion end retrigger settling.
// - External start acts on falling edge only.
// - Clock option overflow triggers a conversion.
// - Quasi-differential: sample signal and subtract return in the same cycles.
// - Hardware start during settling sets the error flag.
// - Error interrupt while flag and enable set.
// - Clock overflow starts only when enabled.
module asv_ctrl #(
	parameter logic [8:0] VEC_SWITCH = asv_pkg::ASV_VEC_DEFAULT, // Factory switch setting.
	parameter int SETTLE_CYC = asv_pkg::ASV_SETTLE_CYC // Settling interval in cycles.
) (
	input wire logic aclk, // Clock, 200 MHz.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic [7:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [7:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	input wire logic [8:0] vec_switch, // Done vector switch bank.
	input wire logic mode_jumper, // High when the single-ended jumper is fitted.
	input wire logic mode_pin_n, // Connector mode pin, low selects single-ended.
	input wire logic ext_start_n, // External start, falling edge starts.
	input wire logic clk_overflow, // Clock option overflow pulse, same clock.
	input wire logic conv_end, // Converter finished its approximation steps.
	output logic single_ended, // Single-ended mode selected.
	output logic sample_hold, // Hold the signal input sample.
	output logic subtract_return, // Reference is the return input.
	output logic [3:0] chan_sel, // Multiplexer channel.
	output logic [8:0] done_vector, // Conversion-complete vector.
	output logic [8:0] err_vector, // Error vector.
	output logic done_irq, // Done interrupt request.
	output logic err_irq // Error interrupt request.
);
	import asv_pkg::*;

	typedef enum logic [2:0] {
		ASV_IDLE = 3'b001,
		ASV_WAIT = 3'b010,
		ASV_CONV = 3'b100
	} asv_state_type;

	asv_state_type state;
	logic [15:0] ctrl;
	logic done_flag;
	logic [8:0] vec_live;
	logic [31:0] settle_cnt;
	logic [7:0] conv_cnt;
	logic ext_level;
	logic ext_level_d;
	logic ext_fall;
	logic ovf_start;
	logic hw_start;
	logic settling;
	logic chan_write;
	logic sw_start;
	logic conv_done;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic rd_ctrl;
	logic mode_pin_s;
	logic unused_conv_end;

	function automatic logic [31:0] asv_merge(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = val[i*8 +: 8];
			end
		end
		return res;
	endfunction : asv_merge

	assign unused_conv_end = conv_end;

	asv_sync u_ext_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.rst_val(1'b1),
		.din(ext_start_n),
		.dout(ext_level)
	);

	asv_sync u_mode_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.rst_val(1'b1),
		.din(mode_pin_n),
		.dout(mode_pin_s)
	);

	// One pulse per filtered falling edge of the external start.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_level_d <= 1'b1;
		end else begin
			ext_level_d <= ext_level;
		end
	end
	assign ext_fall = ext_level_d & ~ext_level & ctrl[ASV_EXT_EN_BIT];
	assign ovf_start = clk_overflow & ctrl[ASV_CLK_EN_BIT];
	assign hw_start = ext_fall | ovf_start;
	assign settling = (settle_cnt != 32'h0000_0000);

	// AXI4-Lite write path: address and data taken in either order.
	assign do_write = aw_held & w_held & ~s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ASV_RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[7:2] == ASV_CTRL_ADDR[7:2]) ? ASV_RESP_OKAY : ASV_RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid & aresetn;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid & aresetn;

	logic [31:0] ctrl_wr;
	assign ctrl_wr = asv_merge({16'h0000, ctrl}, w_data, w_strb);
	assign rd_ctrl = do_write & (aw_addr[7:2] == ASV_CTRL_ADDR[7:2]);
	assign chan_write = rd_ctrl & w_strb[1];
	assign sw_start = rd_ctrl & ctrl_wr[ASV_START_BIT];

	// Control register; hardware error set wins over a software clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= 16'h0000;
		end else begin
			if (rd_ctrl) begin
				ctrl <= ctrl_wr[15:0] & 16'hCF71;
			end
			if (conv_done) begin
				ctrl[ASV_START_BIT] <= 1'b0;
			end
			if (hw_start & settling) begin
				ctrl[ASV_ERR_BIT] <= 1'b1;
			end
		end
	end

	// Conversion sequencer with settling interval.
	assign conv_done = (state == ASV_CONV) && (conv_cnt == 8'(ASV_CONV_STEPS * ASV_STEP_CYC - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ASV_IDLE;
			conv_cnt <= 8'h00;
		end else begin
			case (state)
				ASV_IDLE: begin
					if (hw_start) begin
						state <= ASV_CONV; // Hardware starts do not wait for settling.
					end else if (sw_start) begin
						state <= ASV_WAIT;
					end
					conv_cnt <= 8'h00;
				end
				ASV_WAIT: begin
					if (hw_start || !settling) begin
						state <= ASV_CONV;
					end
				end
				ASV_CONV: begin
					conv_cnt <= conv_cnt + 8'h01;
					if (conv_done) begin
						state <= ASV_IDLE;
						conv_cnt <= 8'h00;
					end
				end
				default: begin
					state <= ASV_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			settle_cnt <= 32'h0000_0000;
		end else if (chan_write || conv_done) begin
			settle_cnt <= 32'(SETTLE_CYC);
		end else if (settling) begin
			settle_cnt <= settle_cnt - 32'h0000_0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_flag <= 1'b0;
		end else if (conv_done) begin
			done_flag <= 1'b1;
		end else if (s_axi_arvalid & s_axi_arready & (s_axi_araddr[7:2] == ASV_STAT_ADDR[7:2])) begin
			done_flag <= 1'b0;
		end
	end

	// Vector switches are sampled each cycle; factory default applies in reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vec_live <= ASV_VEC_DEFAULT;
		end else begin
			vec_live <= vec_switch;
		end
	end

	// Registered outputs.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			single_ended <= 1'b0;
			sample_hold <= 1'b0;
			subtract_return <= 1'b0;
			chan_sel <= 4'h0;
			done_vector <= ASV_VEC_DEFAULT;
			err_vector <= ASV_VEC_DEFAULT + ASV_ERR_VEC_STEP;
			done_irq <= 1'b0;
			err_irq <= 1'b0;
		end else begin
			single_ended <= mode_jumper | ~mode_pin_s;
			sample_hold <= (state == ASV_CONV);
			subtract_return <= (state == ASV_CONV) & ~(mode_jumper | ~mode_pin_s);
			chan_sel <= ctrl[ASV_CHAN_LSB +: 4];
			done_vector <= vec_live;
			err_vector <= vec_live + ASV_ERR_VEC_STEP;
			done_irq <= done_flag & ctrl[ASV_DONE_IE_BIT];
			err_irq <= ctrl[ASV_ERR_BIT] & ctrl[ASV_ERR_IE_BIT];
		end
	end

	// AXI4-Lite read path, one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= ASV_RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= ASV_RESP_OKAY;
			case (s_axi_araddr[7:2])
				ASV_CTRL_ADDR[7:2]: s_axi_rdata <= {16'h0000, ctrl};
				ASV_STAT_ADDR[7:2]: s_axi_rdata <= {24'h00_0000, done_flag, 2'b00, err_irq, single_ended,
					(state == ASV_CONV), settling, 1'b0};
				ASV_VEC_ADDR[7:2]: s_axi_rdata <= {7'h00, err_vector, 7'h00, done_vector};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= ASV_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_arready = ~s_axi_rvalid & aresetn;

	a_settle_load: assert property (@(posedge aclk) disable iff (!aresetn)
		(chan_write || conv_done) |=> (settle_cnt == 32'(SETTLE_CYC))) else $error("settle not loaded");
	a_settle_err: assert property (@(posedge aclk) disable iff (!aresetn)
		(hw_start && settling) |=> ctrl[ASV_ERR_BIT]) else $error("error flag missed");
	a_err_irq_out: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl[ASV_ERR_BIT] && ctrl[ASV_ERR_IE_BIT]) |=> err_irq) else $error("error irq missing");
	a_err_vec_off: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 (err_vector == done_vector + ASV_ERR_VEC_STEP)) else $error("error vector offset");
	a_ovf_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_overflow && !ctrl[ASV_CLK_EN_BIT] && !ext_fall && !sw_start && (state == ASV_IDLE))
		|=> (state == ASV_IDLE)) else $error("ungated overflow");
	a_ext_single: assert property (@(posedge aclk) disable iff (!aresetn)
		ext_fall |=> !ext_fall) else $error("double start pulse");
	a_mode_se: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(mode_jumper) |=> single_ended) else $error("jumper ignored");
	a_vec_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(vec_switch) |=> ##1 (done_vector == $past(vec_switch, 2))) else $error("vector stale");
endmodule : asv_ctrl
`default_nettype wire

// *** testbench/asv_start_src.sv ***
`timescale 1ns/10ps
`default_nettype none
// Stands in for the instrument and the clock option that feed the start inputs.
module asv_start_src (
	input wire logic aclk, // Clock.
	input wire logic go_low, // Request a falling edge.
	input wire logic go_high, // Request a rising edge.
	input wire logic go_ovf, // Request one overflow pulse.
	output var logic ext_start_n, // External start line, idles high.
	output var logic clk_overflow // Overflow pulse on the same clock.
);
	// The instrument is not tied to our clock, so its line moves between edges.
	// One process owns both lines so that each has a single driver.
	initial begin
		ext_start_n = 1'b1;
		clk_overflow = 1'b0;
		forever begin
			@(posedge aclk);
			if (go_low)
				ext_start_n <= #1.7 1'b0;
			if (go_high)
				ext_start_n <= #1.7 1'b1;
			clk_overflow <= go_ovf;
		end
	end
endmodule : asv_start_src
`default_nettype wire

// *** testbench/adc_start_vector_control_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module adc_start_vector_control_test;
	import asv_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, d;
	logic [8:0] vec_switch = 9'o400;
	logic [8:0] done_vector, err_vector, v;
	logic mode_jumper = 1'b0;
	logic mode_pin_n = 1'b1;
	logic conv_end = 1'b0;
	logic ext_start_n, clk_overflow, single_ended, sample_hold, subtract_return, done_irq, err_irq;
	logic [3:0] chan_sel;
	logic [2:0] go = 3'h0;
	int mismatches = 0;
	int checks_done = 0;

	always #2.5 aclk = ~aclk;

	asv_ctrl #(.SETTLE_CYC(20)) u_asv_ctrl (.*);
	asv_start_src u_asv_start_src (.aclk, .go_low(go[0]), .go_high(go[1]), .go_ovf(go[2]), .ext_start_n,
		.clk_overflow);

	function automatic logic exp_se(input logic j, input logic p);
		return j | ~p;
	endfunction : exp_se

	function automatic logic [8:0] exp_err(input logic [8:0] x);
		return x + 9'o010;
	endfunction : exp_err

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic axw(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s, output logic [1:0] rs);
		logic ha, hw, hb;
		hb = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= wd;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!hb) begin
			@(negedge aclk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			hb = s_axi_bvalid && s_axi_bready;
			rs = s_axi_bresp;
			@(posedge aclk);
			if (ha)
				s_axi_awvalid <= 1'b0;
			if (hw)
				s_axi_wvalid <= 1'b0;
			if (hb)
				s_axi_bready <= 1'b0;
		end
		@(posedge aclk);
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
		logic ha, hr;
		hr = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!hr) begin
			@(negedge aclk);
			ha = s_axi_arvalid && s_axi_arready;
			hr = s_axi_rvalid && s_axi_rready;
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (ha)
				s_axi_arvalid <= 1'b0;
			if (hr)
				s_axi_rready <= 1'b0;
		end
		@(posedge aclk);
	endtask : axr

	task automatic kick(input logic [2:0] k);
		go <= k;
		@(posedge aclk);
		go <= 3'h0;
		repeat (8) @(posedge aclk);
	endtask : kick

	task automatic wait_clear(input int b);
		int n;
		n = 0;
		do begin
			axr(ASV_STAT_ADDR, d, r);
			n++;
		end while (d[b] && n < 100);
	endtask : wait_clear

	task automatic print_verdict;
		if (mismatches == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict

	initial begin
		#100000;
		mismatches++;
		print_verdict();
	end

	initial begin
		v = 9'($urandom(32'ha519));
		repeat (19) @(posedge aclk);
		chk("reset vector", ASV_VEC_DEFAULT, done_vector);
		@(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 9'o000 : (i == 1) ? 9'o777 : 9'($urandom);
			vec_switch <= v;
			repeat (4) @(posedge aclk);
			chk("done vector", v, done_vector);
			chk("error vector", exp_err(v), err_vector);
			axr(ASV_VEC_ADDR, d, r);
			chk("vector reg", {7'h0, exp_err(v), 7'h0, v}, d);
		end
		for (int i = 0; i < 4; i++) begin
			mode_jumper <= i[0];
			mode_pin_n <= i[1];
			repeat (8) @(posedge aclk);
			chk("single ended", exp_se(i[0], i[1]), single_ended);
		end
		mode_jumper <= 1'b0;
		axw(8'h0C, 32'h0, 4'hF, r);
		chk("unmapped write", ASV_RESP_SLVERR, r);
		axw(ASV_STAT_ADDR, 32'h0, 4'hF, r);
		chk("status write", ASV_RESP_SLVERR, r);
		axr(8'h10, d, r);
		chk("unmapped read", ASV_RESP_SLVERR, r);
		// A start inside the settling window converts at once but flags an error.
		v = 9'($urandom);
		axw(ASV_CTRL_ADDR, {16'h0, 4'h4, v[3:0], 8'h10}, 4'hF, r);
		chk("channel", v[3:0], chan_sel);
		axr(ASV_STAT_ADDR, d, r);
		chk("settling on channel", 1, d[ASV_SETTLE_BIT]);
		kick(3'h1);
		chk("error irq", 1, err_irq);
		axr(ASV_CTRL_ADDR, d, r);
		chk("error flag", 1, d[ASV_ERR_BIT]);
		chk("sample hold", 1, sample_hold);
		chk("subtract return", 1, subtract_return);
		wait_clear(ASV_BUSY_BIT);
		chk("settling on end", 1, d[ASV_SETTLE_BIT]);
		chk("done", 1, d[ASV_DONE_BIT]);
		kick(3'h2);
		for (int i = 0; i < 3; i++) begin
			d = {16'h0, (i == 0) ? 8'h80 : (i == 1) ? 8'hC0 : 8'h40, 8'h10};
			axw(ASV_CTRL_ADDR, d, 4'h3, r);
			@(posedge aclk);
			chk("error irq order", i == 1, err_irq);
		end
		wait_clear(ASV_SETTLE_BIT);
		kick(3'h1);
		axr(ASV_STAT_ADDR, d, r);
		chk("busy on fall", 1, d[ASV_BUSY_BIT]);
		axr(ASV_CTRL_ADDR, d, r);
		chk("no error", 0, d[ASV_ERR_BIT]);
		wait_clear(ASV_BUSY_BIT);
		wait_clear(ASV_SETTLE_BIT);
		kick(3'h2);
		axr(ASV_STAT_ADDR, d, r);
		chk("busy on rise", 0, d[ASV_BUSY_BIT]);
		for (int i = 0; i < 2; i++) begin
			axw(ASV_CTRL_ADDR, {24'h0, i[0], i[0], 5'h0}, 4'h1, r);
			kick(3'h4);
			axr(ASV_STAT_ADDR, d, r);
			chk("busy on overflow", i, d[ASV_BUSY_BIT]);
			repeat (60) @(posedge aclk);
			chk("done irq", i, done_irq);
			wait_clear(ASV_BUSY_BIT);
			wait_clear(ASV_SETTLE_BIT);
		end
		print_verdict();
	end
endmodule : adc_start_vector_control_test
`default_nettype wire
